/* File: logic/pia_core.sv */
// The address map and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module pia_core #(
  parameter int NUM_SRC = 23
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic srst,
  input wire logic resetPinN,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sources.
  input wire logic [2:0] cpuIrqReq,
  input wire logic nmiPin,
  input wire logic watchdogIrq,
  input wire logic extIrqLevelOrRise,
  input wire logic extIrqAEdgeSelect,
  input wire logic extIrqARiseOnly,
  input wire logic extIrqBEdgeSelect,
  input wire logic extIrqBRiseOnly,
  input wire logic [13:0] periphIrq,
  // CPU instruction events.
  input wire logic setMaskInstruction,
  input wire logic maskAllInstruction,
  input wire logic [2:0] setMaskOperand,
  input wire logic returnFromIrqInstruction,
  input wire logic [23:0] poppedPc,
  input wire logic [15:0] poppedStatus,
  // CPU state and entry outputs.
  output logic [23:0] programCounter,
  output logic [31:0] systemStackPointer,
  output logic [2:0] cpuIrqMask,
  output logic systemModeFlag,
  output logic maxModeFlag,
  output logic [2:0] registerBankPointer,
  output logic [2:0] presentedLevel,
  output logic [4:0] presentedVector,
  output logic stackPush,
  output logic [23:0] stackPc,
  output logic [15:0] stackStatus,
  output logic entryDone,
  output logic dmaStart,
  output logic [1:0] dmaChannel,
  // Pins held during reset.
  output logic watchdogOutputPin,
  output logic clockOutPin,
  output logic aleOutPin,
  output logic peripheralInit
);
  import pia_pkg::*;

  // ****************************************************************
  // Reset acceptance.
  // ****************************************************************
  // Pin reset counts as accepted after ten low cycles; shorter pulses
  // are ignored so glitches cannot wipe the CPU state.
  logic [3:0] rstCount_q;
  logic cpuRst;
  always_ff @(posedge clock) begin
    if (srst || resetPinN) begin
      rstCount_q <= 4'h0;
    end else if (rstCount_q != 4'(PIA_RESET_MIN_CYCLES)) begin
      rstCount_q <= rstCount_q + 4'h1;
    end
  end
  assign cpuRst = srst || (rstCount_q == 4'(PIA_RESET_MIN_CYCLES));

  always_ff @(posedge clock) begin
    watchdogOutputPin <= !cpuRst;
    clockOutPin <= 1'b1;
    aleOutPin <= 1'b0;
    peripheralInit <= cpuRst;
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************
  logic [2:0] prio_q [NUM_SRC];
  logic [4:0] dmaVec_q [PIA_NUM_DMA];
  logic nmiRise_q, int0Edge_q, int4Fall_q, int6Fall_q, bus8_q;
  logic apbWr;
  assign apbWr = psel && penable && pwrite;

  // ****************************************************************
  // Edge sensing and pending requests.
  // ****************************************************************
  logic [4:0] pinNow, pinOld_q, pinHit;
  logic [NUM_SRC-1:0] rawReq, pend_q, clrReq;
  assign pinNow = {extIrqBRiseOnly, extIrqBEdgeSelect, extIrqARiseOnly,
                   extIrqAEdgeSelect, extIrqLevelOrRise};
  logic nmiOld_q, nmiHit;
  // History follows the pins even in reset, so the first cycle after reset
  // never sees a false edge against an idle pin.
  always_ff @(posedge clock) begin
    pinOld_q <= pinNow;
    nmiOld_q <= nmiPin;
  end
  assign nmiHit = nmiRise_q ? (nmiPin && !nmiOld_q)
                            : (!nmiPin && nmiOld_q);
  assign pinHit[0] = int0Edge_q ? (pinNow[0] && !pinOld_q[0])
                                : pinNow[0];
  assign pinHit[1] = int4Fall_q ? (!pinNow[1] && pinOld_q[1])
                                : (pinNow[1] && !pinOld_q[1]);
  assign pinHit[2] = pinNow[2] && !pinOld_q[2];
  assign pinHit[3] = int6Fall_q ? (!pinNow[3] && pinOld_q[3])
                                : (pinNow[3] && !pinOld_q[3]);
  assign pinHit[4] = pinNow[4] && !pinOld_q[4];
  // The watchdog is one of the fourteen internal sources, so only thirteen
  // peripheral lines fit; the top line is a spare and is ignored.
  assign rawReq = {periphIrq[12:0], pinHit, watchdogIrq, nmiHit,
                   cpuIrqReq};

  // Set wins over the grant clear so an event in the clear cycle stays.
  always_ff @(posedge clock) begin
    if (cpuRst) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~clrReq) | rawReq;
    end
  end

  // ****************************************************************
  // Priority resolution.
  // ****************************************************************
  logic [2:0] lvl [NUM_SRC];
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : gLvl
      // Non-maskable sources ignore their programmed field.
      assign lvl[g] = (g <= PIA_SRC_WDT) ? PIA_LEVEL_NMI : prio_q[g];
    end
  endgenerate

  logic [2:0] bestLvl;
  logic [4:0] bestIdx;
  logic bestAny;
  always_comb begin
    bestLvl = 3'h0;
    bestIdx = 5'h00;
    bestAny = 1'b0;
    // Descending scan with >= keeps the lowest index on ties.
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pend_q[i] && lvl[i] != 3'h0 && (!bestAny || lvl[i] >= bestLvl)) begin
        bestLvl = lvl[i];
        bestIdx = 5'(i);
        bestAny = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Acceptance and entry sequence.
  // ****************************************************************
  pia_state_type state_q;
  logic [4:0] entryCnt_q, entryLen;
  logic [4:0] grantVec_q;
  logic [2:0] grantLvl_q;
  logic accept;
  assign entryLen = bus8_q ? (maxModeFlag ? PIA_ENTRY_MAX8 : PIA_ENTRY_MIN8)
                           : (maxModeFlag ? PIA_ENTRY_MAX16
                                          : PIA_ENTRY_MIN16);
  assign accept = bestAny && (bestLvl > cpuIrqMask) &&
                  (state_q != PIA_ENTRY);
  always_comb begin
    clrReq = '0;
    if (accept) begin
      clrReq[bestIdx] = 1'b1;
    end
  end

  logic dmaHit;
  logic [1:0] dmaHitCh;
  always_comb begin
    dmaHit = 1'b0;
    dmaHitCh = 2'h0;
    for (int c = PIA_NUM_DMA - 1; c >= 0; c--) begin
      if (dmaVec_q[c] == bestIdx && dmaVec_q[c] != 5'h00) begin
        dmaHit = 1'b1;
        dmaHitCh = 2'(c);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (cpuRst) begin
      state_q <= PIA_IDLE;
      entryCnt_q <= 5'h00;
      grantVec_q <= 5'h00;
      grantLvl_q <= 3'h0;
      stackPush <= 1'b0;
      entryDone <= 1'b0;
      dmaStart <= 1'b0;
      dmaChannel <= 2'h0;
      stackPc <= 24'h000000;
      stackStatus <= 16'h0000;
    end else begin
      stackPush <= 1'b0;
      entryDone <= 1'b0;
      dmaStart <= 1'b0;
      unique case (state_q)
        PIA_IDLE, PIA_DONE: begin
          state_q <= PIA_IDLE;
          if (accept && dmaHit) begin
            dmaStart <= 1'b1;
            dmaChannel <= dmaHitCh;
          end else if (accept) begin
            state_q <= PIA_ENTRY;
            grantVec_q <= bestIdx;
            grantLvl_q <= bestLvl;
            entryCnt_q <= 5'h01;
            stackPush <= 1'b1;
            stackPc <= programCounter;
            stackStatus <= {systemModeFlag, 4'h0, cpuIrqMask, maxModeFlag,
                            4'h0, registerBankPointer};
          end
        end
        PIA_ENTRY: begin
          entryCnt_q <= entryCnt_q + 5'h01;
          if (entryCnt_q == entryLen) begin
            state_q <= PIA_DONE;
            entryDone <= 1'b1;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // CPU state.
  // ****************************************************************
  logic [2:0] nextMask;
  assign nextMask = (bestLvl == PIA_LEVEL_NMI) ? PIA_LEVEL_NMI
                                               : bestLvl + 3'h1;
  always_ff @(posedge clock) begin
    if (cpuRst) begin
      programCounter <= PIA_RESET_PC;
      systemStackPointer <= PIA_RESET_SSP;
      cpuIrqMask <= PIA_RESET_MASK;
      systemModeFlag <= 1'b1;
      maxModeFlag <= 1'b0;
      registerBankPointer <= PIA_RESET_BANK;
    end else if (accept && !dmaHit) begin
      cpuIrqMask <= nextMask;
      systemModeFlag <= 1'b1;
      systemStackPointer <= systemStackPointer - 32'h00000006;
      // Entry area stays within 512 bytes since vectors are 16-aligned.
      programCounter <= PIA_ENTRY_BASE + {15'h0000, bestIdx, 4'h0};
    end else if (returnFromIrqInstruction) begin
      programCounter <= poppedPc;
      cpuIrqMask <= poppedStatus[10:8];
      systemModeFlag <= poppedStatus[15];
      maxModeFlag <= poppedStatus[7];
      registerBankPointer <= poppedStatus[2:0];
      systemStackPointer <= systemStackPointer + 32'h00000006;
    end else if (maskAllInstruction) begin
      cpuIrqMask <= PIA_LEVEL_NMI;
    end else if (setMaskInstruction) begin
      cpuIrqMask <= setMaskOperand;
    end
  end

  always_ff @(posedge clock) begin
    if (cpuRst) begin
      presentedLevel <= 3'h0;
      presentedVector <= 5'h00;
    end else if (state_q != PIA_ENTRY) begin
      presentedLevel <= bestLvl;
      presentedVector <= bestIdx;
    end
  end

  // ****************************************************************
  // APB slave, zero wait states.
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (cpuRst) begin
      nmiRise_q <= 1'b0;
      int0Edge_q <= 1'b0;
      int4Fall_q <= 1'b0;
      int6Fall_q <= 1'b0;
      bus8_q <= 1'b0;
      for (int i = 0; i < NUM_SRC; i++) prio_q[i] <= 3'h0;
      for (int c = 0; c < PIA_NUM_DMA; c++) dmaVec_q[c] <= 5'h00;
    end else if (apbWr) begin
      unique case (paddr)
        PIA_REG_CTRL: begin
          {bus8_q, int6Fall_q, int4Fall_q, int0Edge_q, nmiRise_q}
            <= pwdata[4:0];
        end
        PIA_REG_PRIO0, PIA_REG_PRIO1, PIA_REG_PRIO2: begin
          for (int k = 0; k < 8; k++) begin
            if (int'(paddr - PIA_REG_PRIO0) * 2 + k < NUM_SRC) begin
              prio_q[int'(paddr - PIA_REG_PRIO0) * 2 + k] <=
                (pwdata[k*4 +: 3] == 3'h7) ? PIA_LEVEL_MAX_MASKABLE
                                           : pwdata[k*4 +: 3];
            end
          end
        end
        PIA_REG_DMAV: begin
          for (int c = 0; c < PIA_NUM_DMA; c++)
            dmaVec_q[c] <= pwdata[c*8 +: 5];
        end
        default: begin
        end
      endcase
    end
  end

  logic [31:0] rd;
  always_comb begin
    rd = 32'h00000000;
    unique case (paddr)
      PIA_REG_CTRL: rd = {27'h0, bus8_q, int6Fall_q, int4Fall_q,
                          int0Edge_q, nmiRise_q};
      PIA_REG_STATUS: rd = {9'h0, pend_q};
      PIA_REG_PRIO0, PIA_REG_PRIO1, PIA_REG_PRIO2: begin
        for (int k = 0; k < 8; k++)
          if (int'(paddr - PIA_REG_PRIO0) * 2 + k < NUM_SRC)
            rd[k*4 +: 3] = prio_q[int'(paddr - PIA_REG_PRIO0) * 2 + k];
      end
      PIA_REG_DMAV: begin
        for (int c = 0; c < PIA_NUM_DMA; c++)
          rd[c*8 +: 5] = dmaVec_q[c];
      end
      PIA_REG_PC: rd = {8'h00, programCounter};
      PIA_REG_SSP: rd = systemStackPointer;
      PIA_REG_VECTOR: rd = {21'h0, cpuIrqMask, presentedLevel,
                            presentedVector};
      default: rd = 32'h00000000;
    endcase
  end

  logic badAddr;
  assign badAddr = (paddr > PIA_REG_VECTOR) || (paddr[1:0] != 2'h0);
  always_ff @(posedge clock) begin
    if (srst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && badAddr;
      prdata <= (psel && !penable) ? rd : 32'h00000000;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  a_mask_raise: assert property (@(posedge clock) disable iff (cpuRst)
    accept && !dmaHit |=> cpuIrqMask == $past(nextMask))
    else $error("mask not raised on entry");
  a_accept_gt: assert property (@(posedge clock) disable iff (cpuRst)
    accept |-> bestLvl > cpuIrqMask)
    else $error("accepted level not above mask");
  a_entry_jump: assert property (@(posedge clock) disable iff (cpuRst)
    stackPush |-> programCounter[23:9] == PIA_ENTRY_BASE[23:9])
    else $error("entry outside entry area");
  a_sys_mode: assert property (@(posedge clock) disable iff (cpuRst)
    stackPush |-> systemModeFlag)
    else $error("entry without system mode");
  a_entry_len: assert property (@(posedge clock) disable iff (cpuRst)
    stackPush && !bus8_q && !maxModeFlag |-> ##15 entryDone)
    else $error("entry length wrong");
  a_hold_vec: assert property (@(posedge clock) disable iff (cpuRst)
    state_q == PIA_ENTRY && $past(state_q) == PIA_ENTRY
      |-> $stable(presentedVector))
    else $error("vector changed during entry");
  a_reset_state: assert property (@(posedge clock)
    cpuRst |=> programCounter == PIA_RESET_PC && cpuIrqMask == 3'h7)
    else $error("reset state wrong");
  a_mask_all: assert property (@(posedge clock) disable iff (cpuRst)
    maskAllInstruction && !accept && !returnFromIrqInstruction
      |=> cpuIrqMask == 3'h7)
    else $error("mask-all did not set seven");
  a_grant_clr: assert property (@(posedge clock) disable iff (cpuRst)
    accept && !rawReq[bestIdx] |=> !pend_q[$past(bestIdx)])
    else $error("granted request not cleared");

endmodule // pia_core

`default_nettype wire

/* File: logic/pia_pkg.sv */
`default_nettype none

package pia_pkg;

  // ****************************************************************
  // Reset values of the CPU state.
  // ****************************************************************
  localparam logic [23:0] PIA_RESET_PC = 24'h008000;
  localparam logic [31:0] PIA_RESET_SSP = 32'h00000100;
  localparam logic [2:0] PIA_RESET_MASK = 3'h7;
  localparam logic [2:0] PIA_RESET_BANK = 3'h0;
  localparam logic [23:0] PIA_ENTRY_BASE = 24'h008000;
  localparam logic [23:0] PIA_ENTRY_LAST = 24'h0081ff;
  localparam int PIA_RESET_MIN_CYCLES = 10;

  // ****************************************************************
  // Source counts and priority levels.
  // ****************************************************************
  localparam int PIA_NUM_SRC = 23;
  localparam int PIA_NUM_CPU = 3;
  localparam int PIA_NUM_EXT = 6;
  localparam int PIA_NUM_PER = 14;
  localparam int PIA_NUM_DMA = 4;
  localparam logic [2:0] PIA_LEVEL_NMI = 3'h7;
  localparam logic [2:0] PIA_LEVEL_MAX_MASKABLE = 3'h6;

  // ****************************************************************
  // Entry sequence length in states.
  // ****************************************************************
  localparam logic [4:0] PIA_ENTRY_MIN16 = 5'h0f;
  localparam logic [4:0] PIA_ENTRY_MAX16 = 5'h11;
  localparam logic [4:0] PIA_ENTRY_MIN8 = 5'h13;
  localparam logic [4:0] PIA_ENTRY_MAX8 = 5'h17;

  // ****************************************************************
  // Source index layout.
  // ****************************************************************
  localparam int PIA_SRC_NMI = 3;
  localparam int PIA_SRC_WDT = 4;
  localparam int PIA_SRC_EXT0 = 5;

  // ****************************************************************
  // APB register map (byte addresses).
  // ****************************************************************
  localparam logic [7:0] PIA_REG_CTRL = 8'h00;
  localparam logic [7:0] PIA_REG_STATUS = 8'h04;
  localparam logic [7:0] PIA_REG_PRIO0 = 8'h08;
  localparam logic [7:0] PIA_REG_PRIO1 = 8'h0c;
  localparam logic [7:0] PIA_REG_PRIO2 = 8'h10;
  localparam logic [7:0] PIA_REG_DMAV = 8'h14;
  localparam logic [7:0] PIA_REG_PC = 8'h18;
  localparam logic [7:0] PIA_REG_SSP = 8'h1c;
  localparam logic [7:0] PIA_REG_VECTOR = 8'h20;

  typedef enum logic [1:0] {
    PIA_IDLE,
    PIA_ENTRY,
    PIA_DONE
  } pia_state_type;

endpackage

`default_nettype wire

/* File: tb/pia_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ****
// Stack side of the CPU: frames pushed on entry come back on return.
// ****
module pia_cpu_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic srst,
  // Return request from the bench, with its delay in cycles.
  input wire logic retReq,
  input wire logic [1:0] retDelay,
  // Entry frame from the block.
  input wire logic stackPush,
  input wire logic [23:0] stackPc,
  input wire logic [15:0] stackStatus,
  // Frame handed back on return.
  output logic returnFromIrqInstruction,
  output logic [23:0] poppedPc,
  output logic [15:0] poppedStatus
);
  logic [39:0] frames_q[$];
  logic [2:0] retCount_q = 3'h0;

  initial begin
    returnFromIrqInstruction = 1'b0;
    poppedPc = 24'h5a5a5a;
    poppedStatus = 16'ha5a5;
  end

  // Between returns the popped lines change every cycle, so a block that
  // samples them outside the return pulse picks up garbage.
  always @(posedge clock) begin
    returnFromIrqInstruction <= 1'b0;
    poppedPc <= ~poppedPc;
    poppedStatus <= ~poppedStatus;
    if (srst) begin
      frames_q.delete();
      retCount_q <= 3'h0;
    end else begin
      if (stackPush) frames_q.push_back({stackPc, stackStatus});
      if (retReq) retCount_q <= {1'b0, retDelay} + 3'h1;
      else if (retCount_q != 3'h0) retCount_q <= retCount_q - 3'h1;
      if (retCount_q == 3'h1 && frames_q.size() > 0) begin
        returnFromIrqInstruction <= 1'b1;
        {poppedPc, poppedStatus} <= frames_q.pop_back();
      end
    end
  end
endmodule // pia_cpu_model

`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import pia_pkg::*;

  // ****
  // Stimulus and observed signals.
  // ****
  logic clock = 0, srst = 1, resetPinN = 1, psel = 0, penable = 0;
  logic pwrite = 0, pready, pslverr, retReq = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, systemStackPointer;
  logic [5:0] pinBus = 6'h00;
  logic [13:0] periphIrq = 14'h0;
  logic setMaskInstruction = 0, maskAllInstruction = 0;
  logic [2:0] setMaskOperand = 3'h0, cpuIrqMask, registerBankPointer;
  logic [2:0] presentedLevel, expMask = 3'h7;
  logic [1:0] retDelay = 2'h0, dmaChannel;
  logic returnFromIrqInstruction, systemModeFlag, maxModeFlag, stackPush;
  logic entryDone, dmaStart, watchdogOutputPin, clockOutPin, aleOutPin;
  logic peripheralInit;
  logic [4:0] presentedVector;
  logic [23:0] poppedPc, programCounter, stackPc, expPc = 24'h008000;
  logic [15:0] poppedStatus, stackStatus;
  logic [2:0] prio[23];
  int num_errors = 0, tests_run = 0, seed = 33790;

  pia_core #(.NUM_SRC(PIA_NUM_SRC)) dut (
    .clock, .srst, .resetPinN, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cpuIrqReq(3'h0), .nmiPin(pinBus[5]),
    .watchdogIrq(1'b0), .extIrqLevelOrRise(pinBus[0]),
    .extIrqAEdgeSelect(pinBus[1]), .extIrqARiseOnly(pinBus[2]),
    .extIrqBEdgeSelect(pinBus[3]), .extIrqBRiseOnly(pinBus[4]), .periphIrq,
    .setMaskInstruction, .maskAllInstruction, .setMaskOperand,
    .returnFromIrqInstruction, .poppedPc, .poppedStatus, .programCounter,
    .systemStackPointer, .cpuIrqMask, .systemModeFlag, .maxModeFlag,
    .registerBankPointer, .presentedLevel, .presentedVector, .stackPush,
    .stackPc, .stackStatus, .entryDone, .dmaStart, .dmaChannel,
    .watchdogOutputPin, .clockOutPin, .aleOutPin, .peripheralInit
  );

  pia_cpu_model partner (
    .clock, .srst, .retReq, .retDelay, .stackPush, .stackPc, .stackStatus,
    .returnFromIrqInstruction, .poppedPc, .poppedStatus
  );

  initial begin
    forever #5 clock = ~clock;
  end

  // ****
  // Shared tasks.
  // ****
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) chk("pready", 32'(pready), 32'h1);
  endtask

  task automatic setPrio(int s, logic [2:0] p);
    logic [31:0] w;
    logic [7:0] a;
    w = 32'h0;
    prio[s] = p == 3'h7 ? 3'h6 : p;
    for (int i = 0; i < 8 && s / 8 * 8 + i < 23; i++)
      w[4 * i +: 3] = prio[s / 8 * 8 + i];
    a = PIA_REG_PRIO0 + 8'(s / 8 * 4);
    w[4 * (s % 8) +: 3] = p;
    apb(1'b1, a, w);
    w[4 * (s % 8) +: 3] = prio[s];
    apb(1'b0, a, 32'h0);
    if (s >= 8) chk("prio", rd, w);
  endtask

  task automatic maskOp(logic all, logic [2:0] m);
    @(posedge clock);
    setMaskInstruction <= !all;
    maskAllInstruction <= all;
    setMaskOperand <= m;
    @(posedge clock);
    setMaskInstruction <= 1'b0;
    maskAllInstruction <= 1'b0;
    @(posedge clock);
    expMask = all ? 3'h7 : m;
    chk("mask", cpuIrqMask, expMask);
  endtask

  task automatic pulse(logic [13:0] b);
    @(posedge clock);
    periphIrq <= b;
    @(posedge clock);
    periphIrq <= 14'h0;
  endtask

  // Waits for one entry and checks the frame, then the handler state.
  task automatic enter(int s, logic [2:0] lvl, logic dma, output int n);
    n = -1;
    for (int k = 0; k < 40 && n == -1; k++) begin
      @(posedge clock);
      if (stackPush === 1'b1) n = 0;
      if (dmaStart === 1'b1) n = -2;
    end
    chk("dmaSeen", n == -2, dma);
    chk("pushSeen", n == 0, !dma);
    if (n != 0) return;
    chk("stackPc", stackPc, expPc);
    chk("stackMask", stackStatus[10:8], expMask);
    while (entryDone !== 1'b1 && n < 40) begin
      @(posedge clock);
      n++;
    end
    expPc = 24'h008000 + 24'(s * 16);
    expMask = lvl == 3'h7 ? 3'h7 : lvl + 3'h1;
    chk("pc", programCounter, expPc);
    chk("mask", cpuIrqMask, expMask);
    chk("sysMode", systemModeFlag, 1'b1);
  endtask

  task automatic ret(logic [23:0] pc, logic [2:0] m);
    retDelay <= 2'($random(seed));
    retReq <= 1'b1;
    @(posedge clock);
    retReq <= 1'b0;
    for (int k = 0; k < 20 && returnFromIrqInstruction !== 1'b1; k++)
      @(posedge clock);
    @(posedge clock);
    expPc = pc;
    expMask = m;
    chk("retPc", programCounter, pc);
    chk("retMask", cpuIrqMask, m);
  endtask

  // ****
  // Scenarios.
  // ****
  initial begin
    int n, n16, s;
    int ord[3];
    int pinIdx[7], pinCtl[7], pinFall[7];
    logic [2:0] p, lvl, m;
    for (int i = 0; i < 23; i++) prio[i] = 3'h0;
    repeat (8) @(posedge clock);
    chk("rstPc", programCounter, 24'h008000);
    chk("rstSsp", systemStackPointer, 32'h100);
    chk("rstSr", {systemModeFlag, cpuIrqMask, maxModeFlag,
                  registerBankPointer}, 8'hf0);
    chk("rstPins", {watchdogOutputPin, clockOutPin, aleOutPin}, 3'h2);
    chk("rstInit", peripheralInit, 1'b1);
    srst <= 1'b0;
    repeat (3) @(posedge clock);
    chk("runInit", peripheralInit, 1'b0);
    apb(1'b0, PIA_REG_PC, 32'h0);
    chk("pcReg", rd, 32'h8000);
    apb(1'b0, PIA_REG_SSP, 32'h0);
    chk("sspReg", rd, 32'h100);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("slvErr", err, 1'b1);
    $display("test reset done");

    maskOp(1'b0, 3'h4);
    maskOp(1'b1, 3'h4);
    maskOp(1'b0, 3'h3);
    setPrio(10, 3'h3);
    pulse(14'h0001);
    repeat (6) @(posedge clock);
    chk("heldPc", programCounter, expPc);
    chk("presLvl", presentedLevel, 3'h3);
    chk("presVec", presentedVector, 5'd10);
    apb(1'b0, PIA_REG_STATUS, 32'h0);
    chk("pendSet", rd[10], 1'b1);
    maskOp(1'b0, 3'h2);
    enter(10, 3'h3, 1'b0, n16);
    chk("entryLen", n16 == 14 || n16 == 15, 1'b1);
    chk("sspDown", systemStackPointer, 32'h0fa);
    apb(1'b0, PIA_REG_STATUS, 32'h0);
    chk("pendClr", rd[10], 1'b0);
    ret(24'h008000, 3'h2);
    apb(1'b1, PIA_REG_CTRL, 32'h10);
    setPrio(11, 3'h4);
    pulse(14'h0002);
    enter(11, 3'h4, 1'b0, n);
    chk("bus8Len", 32'(n - n16), 32'd4);
    ret(24'h008000, 3'h2);
    apb(1'b1, PIA_REG_CTRL, 32'h0);
    $display("test mask and timing done");

    setPrio(13, 3'h5);
    setPrio(14, 3'h5);
    setPrio(12, 3'h3);
    pulse(14'h001c);
    ord = '{13, 14, 12};
    foreach (ord[i]) begin
      enter(ord[i], prio[ord[i]], 1'b0, n);
      ret(24'h008000, 3'h2);
    end
    $display("test arbitration done");

    maskOp(1'b0, 3'h0);
    setPrio(16, 3'h2);
    setPrio(17, 3'h5);
    pulse(14'h0040);
    fork
      enter(16, 3'h2, 1'b0, n);
      begin
        repeat (4) @(posedge clock);
        pulse(14'h0080);
      end
    join
    enter(17, 3'h5, 1'b0, n);
    ret(24'h008100, 3'h3);
    ret(24'h008000, 3'h0);
    $display("test nesting done");

    apb(1'b1, PIA_REG_DMAV, 32'h00120000);
    setPrio(18, 3'h4);
    pulse(14'h0100);
    enter(18, 3'h4, 1'b1, n);
    chk("dmaChan", dmaChannel, 2'h2);
    chk("dmaPc", programCounter, expPc);
    apb(1'b1, PIA_REG_DMAV, 32'h0);
    $display("test dma done");

    // Falling-edge rows raise the pin first: a wrong rising trigger would
    // enter early and the entry would be missed, so the row fails.
    for (int i = 5; i < 10; i++) setPrio(i, 3'h6);
    maskOp(1'b0, 3'h5);
    pinIdx = '{3, 3, 5, 6, 7, 8, 9};
    pinCtl = '{0, 1, 2, 4, 0, 8, 0};
    pinFall = '{1, 0, 0, 1, 0, 1, 0};
    foreach (pinIdx[i]) begin
      s = pinIdx[i];
      apb(1'b1, PIA_REG_CTRL, 32'(pinCtl[i]));
      pinBus[s == 3 ? 5 : s - 5] <= 1'b1;
      if (pinFall[i] != 0) begin
        repeat (3) @(posedge clock);
        pinBus[s == 3 ? 5 : s - 5] <= 1'b0;
      end
      enter(s, s == 3 ? 3'h7 : 3'h6, 1'b0, n);
      pinBus <= 6'h00;
      ret(24'h008000, 3'h5);
    end
    $display("test pins done");

    for (int i = 0; i < 6; i++) begin
      s = 19 + $unsigned($random(seed)) % 4;
      p = 3'(1 + $unsigned($random(seed)) % 7);
      m = 3'($unsigned($random(seed)) % 7);
      lvl = p == 3'h7 ? 3'h6 : p;
      setPrio(s, p);
      maskOp(1'b0, m);
      pulse(14'h1 << (s - 10));
      if (lvl <= m) begin
        repeat (5) @(posedge clock);
        chk("maskedPc", programCounter, expPc);
        m = lvl - 3'h1;
        maskOp(1'b0, m);
      end
      enter(s, lvl, 1'b0, n);
      ret(24'h008000, m);
    end
    $display("test random done");

    maskOp(1'b0, 3'h2);
    apb(1'b1, PIA_REG_CTRL, 32'h1f);
    apb(1'b0, PIA_REG_CTRL, 32'h0);
    chk("ctrlRw", rd, 32'h1f);
    resetPinN <= 1'b0;
    repeat (9) @(posedge clock);
    resetPinN <= 1'b1;
    repeat (3) @(posedge clock);
    chk("shortRst", cpuIrqMask, 3'h2);
    resetPinN <= 1'b0;
    repeat (14) @(posedge clock);
    chk("pinRstPins", {watchdogOutputPin, clockOutPin, aleOutPin}, 3'h2);
    resetPinN <= 1'b1;
    repeat (3) @(posedge clock);
    chk("pinRstSr", {systemModeFlag, cpuIrqMask}, 4'hf);
    apb(1'b0, PIA_REG_CTRL, 32'h0);
    chk("pinRstCtrl", rd, 32'h0);
    $display("test pin reset done");
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    $display("BAD watchdog expected done seen timeout");
    close_out();
  end
endmodule // tb_top

`default_nettype wire
